// ===== src/udb_defines.svh
`ifndef UDB_DEFINES_SVH
`define UDB_DEFINES_SVH

// ==========================================================
// Timing, in ns and in clk_sys cycles of 5 ns
`define UDB_CLK_NS    5
`define UDB_T_ACK_NS  20
`define UDB_ACK_CYC   ((`UDB_T_ACK_NS + `UDB_CLK_NS - 1) / `UDB_CLK_NS)
`define UDB_SS_CYC    8
`define UDB_STB_DIV   12

// ==========================================================
// Widths and host control values
`define UDB_W         16
`define UDB_CS_IDLE   2'h2
`define UDB_DA_IDLE   3'h7
`define UDB_CS_BURST  2'h3
`define UDB_DA_BURST  3'h0
`define UDB_STOP_IDLE 1'h1

`endif

// ===== src/udb_pkg.sv
package udb_pkg;

  // ==========================================================
  // State machines
  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_REQ  = 5'h02,
    D_IN   = 5'h04,
    D_OUT  = 5'h08,
    D_TERM = 5'h10
  } udb_dev_st_t;

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_SET  = 6'h02,
    H_IN   = 6'h04,
    H_OUT  = 6'h08,
    H_TERM = 6'h10,
    H_HOLD = 6'h20
  } udb_hst_st_t;

  // ==========================================================
  // Saturating timer step, shared by both ends
  function automatic logic [7:0] udb_inc(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction : udb_inc

endpackage : udb_pkg

// ===== src/udb_if.sv
`timescale 1ns/1ps
`include "udb_defines.svh"

// ==========================================================
// Burst link between host and device
interface udb_if #(parameter int W = `UDB_W);
  logic         dmarq;
  logic         dmack_n;
  logic         stop;
  logic         hrdy_n;
  logic [1:0]   cs_n;
  logic [2:0]   da;
  logic         dev_rdy_o;
  logic         dev_rdy_oe;
  logic         dev_rdy;
  logic [W-1:0] dd_dev_o;
  logic         dd_dev_oe;
  logic [W-1:0] dd_host_o;
  logic         dd_host_oe;
  logic [W-1:0] dd;

  // Host pull-up makes a released ready/strobe line read high
  assign dev_rdy = dev_rdy_oe ? dev_rdy_o : 1'b1;
  assign dd      = dd_dev_oe ? dd_dev_o : (dd_host_oe ? dd_host_o : '0);

  modport dev (output dmarq, dev_rdy_o, dev_rdy_oe, dd_dev_o, dd_dev_oe,
               input dmack_n, stop, hrdy_n, dd);
  modport host (output dmack_n, stop, hrdy_n, cs_n, da, dd_host_o, dd_host_oe,
                input dmarq, dev_rdy, dd);
endinterface : udb_if

// ===== src/udb_dev.sv
`timescale 1ns/1ps
`include "udb_defines.svh"
// Operation
// [R1] Drive ready/strobe only while acknowledge asserted
// [R2] Leave ready/strobe undriven outside a burst
// [R3] First data-in strobe edge is high-to-low
// [R4] Enable strobe high late, or early then low
// [R5] Data-out ready stays negated until room exists
// [R6] Host settles controls 20 ns around acknowledge
// [R7] Burst spans acknowledge assert to negate
// [R8] Sender waits a gap after last strobe
// [R9] Same termination gap in every mode
// [R10] Gaps timed by counters in own clock

// ==========================================================
// Device end
module udb_dev
  import udb_pkg::*;
#(
  parameter int W           = `UDB_W,
  parameter int SS_CYC      = `UDB_SS_CYC,
  parameter int STB_DIV     = `UDB_STB_DIV,
  parameter bit EARLY_DRIVE = 1'b0
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  udb_if.dev                lnk,
  input  wire logic         in_req,
  input  wire logic [W-1:0] tx_data,
  input  wire logic         tx_valid,
  output logic              tx_ready,
  input  wire logic         out_req,
  output logic [W-1:0]      rx_data,
  output logic              rx_valid,
  input  wire logic         rx_ready,
  output logic              busy
);
  logic [2:0]   ctl_s1_r;
  logic [2:0]   ctl_s2_r;
  logic [W-1:0] dd_s1_r;
  logic [W-1:0] dd_s2_r;
  logic         hstb_d_r;
  logic         ack_s;
  logic         stop_s;
  logic         hrdy_s;
  logic         hstb_edge;
  udb_dev_st_t  state_r;
  udb_dev_st_t  st_nxt;
  logic         dir_in_r;
  logic         dmarq_r;
  logic         rdy_o_r;
  logic         rdy_oe_r;
  logic [W-1:0] dd_o_r;
  logic         dd_oe_r;
  logic         pend_r;
  logic [7:0]   tmr_r;
  logic         load;
  logic         fire;
  logic         gap_ok;
  logic [1:0]   rxq_cnt;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_s1_r <= 3'h7;
      ctl_s2_r <= 3'h7;
      dd_s1_r  <= '0;
      dd_s2_r  <= '0;
      hstb_d_r <= 1'b1;
    end
    else
    begin
      ctl_s1_r <= {lnk.dmack_n, lnk.stop, lnk.hrdy_n};
      ctl_s2_r <= ctl_s1_r;
      dd_s1_r  <= lnk.dd;
      dd_s2_r  <= dd_s1_r;
      hstb_d_r <= ctl_s2_r[0];
    end
  end

  assign ack_s     = ~ctl_s2_r[2];
  assign stop_s    = ctl_s2_r[1];
  assign hrdy_s    = ctl_s2_r[0];
  assign hstb_edge = hrdy_s ^ hstb_d_r;

  // ==========================================================
  // Sender timing; one timer serves strobe spacing and the gap
  // Word due once the line has been still for a strobe period
  assign load     = (state_r == D_IN) && tx_valid && !pend_r && (tmr_r >= 8'(STB_DIV)) && !stop_s;
  // Strobe only while the host holds its ready asserted
  assign fire     = (state_r == D_IN) && pend_r && (tmr_r >= 8'(STB_DIV)) && !hrdy_s && !stop_s;
  // Same gap whatever the mode; no per-mode shortening
  assign gap_ok   = !pend_r && (tmr_r >= 8'(SS_CYC)); // [R8] [R9] [R10]
  assign tx_ready = load;
  assign busy     = (state_r != D_IDLE);

  // Next state; the burst lives between acknowledge edges
  always_comb
  begin
    st_nxt = state_r;
    unique case (state_r)
      D_IDLE:
        if (in_req || out_req)
          st_nxt = D_REQ;
      D_REQ:
        if (ack_s)
          st_nxt = dir_in_r ? D_IN : D_OUT; // [R7]
      D_IN:
        if (!ack_s)
          st_nxt = D_IDLE;
        else if (stop_s || (!in_req && gap_ok))
          st_nxt = D_TERM; // [R8]
      D_OUT:
        if (!ack_s)
          st_nxt = D_IDLE;
        else if (stop_s || (!out_req && gap_ok))
          st_nxt = D_TERM;
      D_TERM:
        if (!ack_s)
          st_nxt = D_IDLE; // [R7]
      default:
        st_nxt = D_IDLE;
    endcase
  end

  // State, direction and request
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r  <= D_IDLE;
      dir_in_r <= 1'b0;
      dmarq_r  <= 1'b0;
    end
    else
    begin
      state_r <= st_nxt;
      dmarq_r <= (st_nxt == D_REQ) || (st_nxt == D_IN) || (st_nxt == D_OUT);
      if (state_r == D_IDLE)
        dir_in_r <= in_req;
    end
  end

  // ==========================================================
  // Ready/strobe line
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdy_oe_r <= 1'b0;
      rdy_o_r  <= 1'b1;
    end
    else if (!ack_s)
    begin
      // Acknowledge gone: release at once, pull-up keeps it high
      rdy_oe_r <= 1'b0; // [R1] [R2]
      rdy_o_r  <= 1'b1;
    end
    else
    begin
      unique case (state_r)
        D_REQ:
        begin
          // Data-out enables negated; data-in only if driving early
          rdy_oe_r <= !dir_in_r || EARLY_DRIVE; // [R4] [R5]
          rdy_o_r  <= 1'b1;
        end
        D_IN:
        begin
          if (load)
            rdy_oe_r <= 1'b1; // [R4]
          // Line was high for a strobe period, so first edge falls
          if (fire)
            rdy_o_r <= ~rdy_o_r; // [R3]
        end
        // Low only with the buffer empty; one late word still fits
        D_OUT:
          rdy_o_r <= (rxq_cnt != 2'h0) || !out_req; // [R5]
        D_TERM:
          rdy_o_r <= 1'b1;
        default:
          rdy_o_r <= 1'b1;
      endcase
    end
  end

  // Word launch and strobe timer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_r  <= 1'b0;
      tmr_r   <= 8'h00;
      dd_o_r  <= '0;
      dd_oe_r <= 1'b0;
    end
    else
    begin
      if ((st_nxt != state_r) || load || fire || ((state_r == D_OUT) && hstb_edge))
        tmr_r <= 8'h00; // [R10]
      else
        tmr_r <= udb_inc(tmr_r);
      if (state_r != D_IN || fire)
        pend_r <= 1'b0;
      else if (load)
        pend_r <= 1'b1;
      if (load)
        dd_o_r <= tx_data;
      dd_oe_r <= (st_nxt == D_IN); // [R2]
    end
  end

  // ==========================================================
  // Receive path; a terminated pending word is lost, not resent
  udb_buf2 #(.W(W)) u_rxq (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_data   (dd_s2_r),
    .in_valid  ((state_r == D_OUT) && hstb_edge && !stop_s), // Closing strobe carries no word
    .in_ready  (),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .count     (rxq_cnt)
  );

  assign lnk.dmarq      = dmarq_r;
  assign lnk.dev_rdy_o  = rdy_o_r;
  assign lnk.dev_rdy_oe = rdy_oe_r;
  assign lnk.dd_dev_o   = dd_o_r;
  assign lnk.dd_dev_oe  = dd_oe_r;
endmodule : udb_dev

// ===== src/udb_host.sv
`timescale 1ns/1ps
`include "udb_defines.svh"

// ==========================================================
// Two-entry buffer
module udb_buf2 #(parameter int W = 16)
(
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [1:0]        count
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  // Handshakes straight from the fill count
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r];
  assign count     = cnt_r;

  // Fill count
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cnt_r <= 2'h0;
    else if (push && !pop)
      cnt_r <= cnt_r + 2'h1;
    else if (pop && !push)
      cnt_r <= cnt_r - 2'h1;
  end

  // Pointers and storage
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
    end
  end
endmodule : udb_buf2

// ==========================================================
// Host end
module udb_host
  import udb_pkg::*;
#(
  parameter int W       = `UDB_W,
  parameter int ACK_CYC = `UDB_ACK_CYC,
  parameter int SS_CYC  = `UDB_SS_CYC,
  parameter int STB_DIV = `UDB_STB_DIV
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  udb_if.host               lnk,
  input  wire logic         dir_out,
  input  wire logic         end_req,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  output logic [W-1:0]      rd_data,
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic              busy
);
  logic [1:0]   ctl_s1_r;
  logic [1:0]   ctl_s2_r;
  logic [W-1:0] dd_s1_r;
  logic [W-1:0] dd_s2_r;
  logic         drdy_d_r;
  logic         dmarq_s;
  logic         drdy_s;
  logic         drdy_edge;
  udb_hst_st_t  state_r;
  udb_hst_st_t  st_nxt;
  logic         dir_out_r;
  logic         dmack_n_r;
  logic         stop_r;
  logic         hrdy_r;
  logic [1:0]   cs_n_r;
  logic [2:0]   da_r;
  logic [W-1:0] dd_o_r;
  logic         dd_oe_r;
  logic         pend_r;
  logic [7:0]   tmr_r;
  logic         load;
  logic         fire;
  logic         gap_ok;
  logic [1:0]   rxq_cnt;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_s1_r <= 2'h1;
      ctl_s2_r <= 2'h1;
      dd_s1_r  <= '0;
      dd_s2_r  <= '0;
      drdy_d_r <= 1'b1;
    end
    else
    begin
      ctl_s1_r <= {lnk.dmarq, lnk.dev_rdy};
      ctl_s2_r <= ctl_s1_r;
      dd_s1_r  <= lnk.dd;
      dd_s2_r  <= dd_s1_r;
      drdy_d_r <= ctl_s2_r[0];
    end
  end

  assign dmarq_s   = ctl_s2_r[1];
  assign drdy_s    = ctl_s2_r[0];
  assign drdy_edge = drdy_s ^ drdy_d_r;

  // ==========================================================
  // Sender timing, mirror of the device side
  assign load     = (state_r == H_OUT) && wr_valid && !pend_r && (tmr_r >= 8'(STB_DIV)) && !end_req;
  assign fire     = (state_r == H_OUT) && pend_r && (tmr_r >= 8'(STB_DIV)) && !drdy_s;
  assign gap_ok   = !pend_r && (tmr_r >= 8'(SS_CYC)); // [R8] [R9]
  assign wr_ready = load;
  assign busy     = (state_r != H_IDLE);

  // Next state
  always_comb
  begin
    st_nxt = state_r;
    unique case (state_r)
      H_IDLE:
        if (dmarq_s)
          st_nxt = H_SET;
      H_SET:
        if (tmr_r >= 8'(ACK_CYC))
          st_nxt = dir_out_r ? H_OUT : H_IN; // [R6]
      H_IN, H_OUT:
        if (!dmarq_s || (end_req && gap_ok))
          st_nxt = H_TERM; // [R8]
      H_TERM:
        if (!dmarq_s)
          st_nxt = H_HOLD;
      H_HOLD:
        if (tmr_r >= 8'(ACK_CYC))
          st_nxt = H_IDLE; // [R6]
      default:
        st_nxt = H_IDLE;
    endcase
  end

  // State, direction and acknowledge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r   <= H_IDLE;
      dir_out_r <= 1'b0;
      dmack_n_r <= 1'b1;
    end
    else
    begin
      state_r   <= st_nxt;
      dmack_n_r <= !((st_nxt == H_IN) || (st_nxt == H_OUT) || (st_nxt == H_TERM)); // [R7]
      if (state_r == H_IDLE)
        dir_out_r <= dir_out;
    end
  end

  // ==========================================================
  // Controls settle before acknowledge and stay through hold
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stop_r <= `UDB_STOP_IDLE;
      cs_n_r <= `UDB_CS_IDLE;
      da_r   <= `UDB_DA_IDLE;
    end
    else if ((state_r == H_IDLE) && (st_nxt == H_SET))
    begin
      stop_r <= 1'b0; // [R6]
      cs_n_r <= `UDB_CS_BURST;
      da_r   <= `UDB_DA_BURST;
    end
    else if ((state_r == H_HOLD) && (st_nxt == H_IDLE))
    begin
      stop_r <= `UDB_STOP_IDLE;
      cs_n_r <= `UDB_CS_IDLE;
      da_r   <= `UDB_DA_IDLE;
    end
    else if (st_nxt == H_TERM)
      stop_r <= 1'b1;
  end

  // Host ready in data-in, host strobe in data-out
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      hrdy_r <= 1'b1;
    else if (st_nxt == H_IN)
      hrdy_r <= (rxq_cnt != 2'h0) || end_req;
    else if (st_nxt == H_OUT)
    begin
      if (fire)
        hrdy_r <= ~hrdy_r;
    end
    else
      hrdy_r <= 1'b1;
  end

  // Word launch and shared timer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_r  <= 1'b0;
      tmr_r   <= 8'h00;
      dd_o_r  <= '0;
      dd_oe_r <= 1'b0;
    end
    else
    begin
      if ((st_nxt != state_r) || load || fire || ((state_r == H_IN) && drdy_edge))
        tmr_r <= 8'h00; // [R10]
      else
        tmr_r <= udb_inc(tmr_r);
      if (state_r != H_OUT || fire)
        pend_r <= 1'b0;
      else if (load)
        pend_r <= 1'b1;
      if (load)
        dd_o_r <= wr_data;
      dd_oe_r <= (st_nxt == H_OUT);
    end
  end

  // ==========================================================
  // Receive path
  udb_buf2 #(.W(W)) u_rxq (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_data   (dd_s2_r),
    .in_valid  ((state_r == H_IN) && drdy_edge),
    .in_ready  (),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .count     (rxq_cnt)
  );

  assign lnk.dmack_n    = dmack_n_r;
  assign lnk.stop       = stop_r;
  assign lnk.hrdy_n     = hrdy_r;
  assign lnk.cs_n       = cs_n_r;
  assign lnk.da         = da_r;
  assign lnk.dd_host_o  = dd_o_r;
  assign lnk.dd_host_oe = dd_oe_r;
endmodule : udb_host

// ===== dv/udb_props.sv
`timescale 1ns/1ps

// ==========================================================
// Link checker, sampled on the device clock
module udb_props #(parameter int SS_CYC = 8)
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       dmarq,
  input wire logic       dmack_n,
  input wire logic       stop,
  input wire logic       hrdy_n,
  input wire logic [1:0] cs_n,
  input wire logic [2:0] da,
  input wire logic       dev_rdy_o,
  input wire logic       dev_rdy_oe,
  input wire logic       dd_dev_oe,
  input wire logic       dd_host_oe
);
  logic       ctl_ok;
  logic       dstb_q_r;
  logic       hstb_q_r;
  logic [7:0] dstb_gap_r;
  logic [7:0] hstb_gap_r;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Burst-state chip selects and address
  assign ctl_ok = (cs_n == 2'h3) && (da == 3'h0);

  // Cycles since the last device strobe edge; starts at 1 so the count matches the sender's
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dstb_q_r   <= 1'b1;
      dstb_gap_r <= 8'hff;
    end
    else
    begin
      dstb_q_r   <= dev_rdy_o;
      dstb_gap_r <= (dev_rdy_oe && dev_rdy_o != dstb_q_r) ? 8'h01 : dstb_gap_r + {7'h00, dstb_gap_r != 8'hff};
    end
  end

  // Cycles since the last host strobe edge
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hstb_q_r   <= 1'b1;
      hstb_gap_r <= 8'hff;
    end
    else
    begin
      hstb_q_r   <= hrdy_n;
      hstb_gap_r <= (dd_host_oe && hrdy_n != hstb_q_r) ? 8'h01 : hstb_gap_r + {7'h00, hstb_gap_r != 8'hff};
    end
  end

  // ==========================================================
  // Burst bracket
  sequence ack_on_s;
    $fell(dmack_n);
  endsequence
  sequence ack_off_s;
    $rose(dmack_n);
  endsequence

  rdy_enable_a: assert property ($rose(dev_rdy_oe) |-> !dmack_n)
    else $error("ready line enabled without acknowledge");
  rdy_release_a: assert property (ack_off_s |-> ##[1:6] !dev_rdy_oe)
    else $error("ready line not released after acknowledge");
  idle_undriven_a: assert property (dmack_n && $past(dmack_n, 6) |-> !dev_rdy_oe)
    else $error("ready line driven outside a burst");
  first_fall_a: assert property ($rose(dev_rdy_oe) && dd_dev_oe |-> dev_rdy_o)
    else $error("strobe enabled low");
  ack_setup_a: assert property (ack_on_s |-> $past(ctl_ok, 4) && !$past(stop, 4) && ctl_ok)
    else $error("controls not settled before acknowledge");
  ack_hold_a: assert property (ack_off_s |-> ctl_ok [*4])
    else $error("controls changed too soon after acknowledge");
  ack_request_a: assert property (ack_on_s |-> dmarq)
    else $error("acknowledge without request");
  ack_end_a: assert property (ack_off_s |-> !$past(dmarq))
    else $error("acknowledge dropped while request held");
  dev_gap_a: assert property ($fell(dmarq) && $past(dd_dev_oe) && !stop |-> dstb_gap_r >= SS_CYC)
    else $error("device ended too soon after strobe");
  host_gap_a: assert property ($rose(stop) && $past(dd_host_oe) |-> hstb_gap_r >= SS_CYC)
    else $error("host ended too soon after strobe");
endmodule : udb_props

// ===== dv/test_udma_burst_bracket_control.sv
`timescale 1ns/1ps

// ==========================================================
// Both ends face each other; bench drives the user sides
module test_udma_burst_bracket_control;
  logic        clk_sys;
  logic        rst_b;
  logic        in_req;
  logic        out_req;
  logic        dir_out;
  logic        end_req;
  logic [15:0] tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [15:0] rx_data;
  logic        rx_valid;
  logic        rx_ready;
  logic [15:0] wr_data;
  logic        wr_valid;
  logic        wr_ready;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        rd_ready;
  logic        dev_busy;
  logic        hst_busy;
  logic        prev_rdy;
  logic [15:0] tx_q[$];
  logic [15:0] wr_q[$];
  logic [15:0] sent_q[$];
  logic [15:0] got_q[$];
  bit          first_seen;
  bit          tx_take;
  bit          wr_take;
  int          hold_cnt;
  int          cyc;
  int          mismatches;
  int          checks_done;

  udb_if #(.W(16)) udb_if_i ();

  udb_dev udb_dev_i (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(udb_if_i), .in_req(in_req), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .out_req(out_req), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .busy(dev_busy));

  udb_host udb_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(udb_if_i), .dir_out(dir_out), .end_req(end_req),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .busy(hst_busy));

  udb_props udb_props_i (.clk_sys(clk_sys), .rst_b(rst_b), .dmarq(udb_if_i.dmarq), .dmack_n(udb_if_i.dmack_n),
    .stop(udb_if_i.stop), .hrdy_n(udb_if_i.hrdy_n), .cs_n(udb_if_i.cs_n), .da(udb_if_i.da),
    .dev_rdy_o(udb_if_i.dev_rdy_o), .dev_rdy_oe(udb_if_i.dev_rdy_oe), .dd_dev_oe(udb_if_i.dd_dev_oe),
    .dd_host_oe(udb_if_i.dd_host_oe));

  always #2.5 clk_sys = ~clk_sys;

  // ==========================================================
  // Compare and closing tasks
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_bit

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // ==========================================================
  // Stimulus at the falling edge; sinks stall at random
  // Handshakes and pins are read once settled: at the rising edge they race the flops
  always @(negedge clk_sys)
  begin
    if (tx_take && tx_q.size() != 0) void'(tx_q.pop_front());
    if (wr_take && wr_q.size() != 0) void'(wr_q.pop_front());
    tx_valid = (tx_q.size() != 0);
    tx_data  = tx_valid ? tx_q[0] : 16'h0000;
    wr_valid = (wr_q.size() != 0);
    wr_data  = wr_valid ? wr_q[0] : 16'h0000;
    if (hold_cnt != 0) hold_cnt--;
    rd_ready = ($urandom % 4) != 0;
    rx_ready = (hold_cnt == 0) && (($urandom % 4) != 0);
    #1;
    tx_take = tx_valid && tx_ready;
    wr_take = wr_valid && wr_ready;
    if (rd_valid && rd_ready) got_q.push_back(rd_data);
    if (rx_valid && rx_ready) got_q.push_back(rx_data);
    if (udb_if_i.dmack_n === 1'b1) first_seen = 1'b0;
    else if (!first_seen && udb_if_i.dev_rdy !== prev_rdy)
    begin
      first_seen = 1'b1;
      chk_bit(udb_if_i.dev_rdy, 1'b0);
    end
    if (hold_cnt == 1 && dir_out && udb_if_i.dmack_n === 1'b0) chk_bit(udb_if_i.dev_rdy, 1'b1);
    prev_rdy = udb_if_i.dev_rdy;
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // One burst; cut above zero makes the host end it after that many words
  task automatic run_burst(input bit to_dev, input int n, input int cut);
    int k;
    sent_q.delete();
    got_q.delete();
    for (k = 0; k < n; k++)
      sent_q.push_back((k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($urandom));
    @(negedge clk_sys);
    dir_out = to_dev;
    if (to_dev) wr_q = sent_q;
    else tx_q = sent_q;
    out_req = to_dev;
    in_req  = !to_dev;
    k = 0;
    while (k < 8000 && got_q.size() < ((cut == 0) ? n : cut))
    begin
      @(negedge clk_sys);
      k++;
    end
    end_req = (cut != 0);
    in_req  = 1'b0;
    out_req = 1'b0;
    tx_q.delete();
    wr_q.delete();
    k = 0;
    while ((dev_busy !== 1'b0 || hst_busy !== 1'b0) && k < 4000)
    begin
      @(negedge clk_sys);
      k++;
    end
    repeat (40) @(negedge clk_sys);
    end_req = 1'b0;
    chk_bit(dev_busy | hst_busy, 1'b0);
    chk_bit(udb_if_i.dev_rdy_oe, 1'b0);
    chk_bit(udb_if_i.dmack_n, 1'b1);
    if (cut == 0) chk_word(16'(got_q.size()), 16'(n));
    else chk_bit(got_q.size() >= cut, 1'b1);
    for (k = 0; k < got_q.size(); k++)
      chk_word(got_q[k], sent_q[k]);
    $display("test done dir %0d words %0d", to_dev, got_q.size());
  endtask : run_burst

  // ==========================================================
  // Main sequence
  initial
  begin
    clk_sys  = 1'b0;
    rst_b    = 1'b0;
    {in_req, out_req, dir_out, end_req, tx_valid, wr_valid, rx_ready, rd_ready} = 8'h00;
    tx_data  = 16'h0000;
    wr_data  = 16'h0000;
    hold_cnt = 0;
    prev_rdy = 1'b1;
    void'($urandom(32'h73b3cc2d));
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_bit(udb_if_i.dev_rdy_oe, 1'b0);
    chk_bit(udb_if_i.dev_rdy, 1'b1);
    $display("test done idle");
    run_burst(1'b0, 12, 0);
    hold_cnt = 400;
    run_burst(1'b1, 10, 0);
    run_burst(1'b0, 1, 0);
    run_burst(1'b0, 12, 5);
    run_burst(1'b1, 10, 4);
    finish_test();
  end
endmodule : test_udma_burst_bracket_control
